// ---- logic/kbd_encoder.sv ----
// keyboard matrix scanner, code former and eight-deep key fifo
`include "kbd_regs.svh"

// How it works
// - a held key queues one code only, no further codes by itself
// - scan disable blanks row drive, so no closure is seen
// - after a scan disable covering a whole pass, a still held key is queued afresh
// - each key event is one 8-bit code read from the data port
// - shift, control, function alter the code; upper_case_latch_key only sensed
// - no modifier gives top bits set; shift clears b6, control b7
// - low six bits are matrix position whatever the modifiers
// - code is column at b2-b0, row at b5-b3, shift low at b6, control low at b7
// - fifo holds eight codes in order, count and full flag reported
// - overrun on closure when full, underrun on read when empty
// - function key acts as shift plus control together
module kbd_encoder (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // key matrix
  output logic      [7:0]             row_drive_n,
  input  wire logic [7:0]             col_return_n,
  input  wire logic                   shift_key_n,
  input  wire logic                   ctrl_key_n,
  input  wire logic                   fn_modifier_key_n,
  input  wire logic                   upper_case_latch_key_n,
  // system control
  input  wire logic                   scan_disable,
  output logic                        caps_sensed_q,
  // data port
  input  wire logic                   data_rd,
  output logic      [7:0]             data_q,
  // status port
  input  wire logic                   err_clear,
  output logic      [3:0]             fifo_count_q,
  output logic                        overrun_q,
  output logic                        underrun_q
);
  localparam int DIV = `KBD_SCAN_DIV;

  logic [7:0]  col_clean;
  logic [2:0]  mod_clean;
  logic [2:0]  mod_raw;
  logic [8:0]  div_q;
  logic        tick;
  logic [2:0]  row_q;
  kbd_pkg::scan_state_t state_q;
  kbd_pkg::scan_state_t state_d;
  logic [5:0]  pos_q;
  logic [1:0]  deb_q;
  logic        pass_hit_q;
  logic [7:0]  mem [0:`KBD_FIFO_DEPTH-1];
  logic [2:0]  wr_ptr_q;
  logic [2:0]  rd_ptr_q;
  logic [3:0]  count_q;
  logic        hit;
  logic [2:0]  hit_col;
  logic        pass_end;
  logic        push;
  logic        pop;
  logic        fifo_full;
  logic        fifo_empty;
  logic        shift_on;
  logic        ctrl_on;
  logic [7:0]  code;
  logic [3:0]  count_d;

  // synchronise column returns and modifier keys
  kbd_sync #(.W(8)) u_col_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .raw   (~col_return_n),
    .clean (col_clean)
  );

  assign mod_raw = {~upper_case_latch_key_n, ~ctrl_key_n | ~fn_modifier_key_n,
                    ~shift_key_n | ~fn_modifier_key_n};

  kbd_sync #(.W(3)) u_mod_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .raw   (mod_raw),
    .clean (mod_clean)
  );

  // scan-rate enable and row decode
  assign tick     = (div_q == 9'(DIV - 1));
  assign pass_end = tick && (row_q == 3'(`KBD_ROWS - 1));
  assign hit      = !scan_disable && (col_clean != 8'h00);

  // lowest active column wins
  always_comb
  begin
    hit_col = 3'h0;
    for (int i = `KBD_ROWS - 1; i >= 0; i--)
      if (col_clean[i])
        hit_col = 3'(i);
  end

  // key code: modifiers low-active in the two top bits, position below
  assign shift_on = mod_clean[0];
  assign ctrl_on  = mod_clean[1];
  assign code     = {~ctrl_on, ~shift_on, pos_q};

  // closure tracking with two-key lockout
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      kbd_pkg::st_idle:
        if (tick && hit)
          state_d = kbd_pkg::st_debounce;
      kbd_pkg::st_debounce:
        if (pass_end && !pass_hit_q && !(hit && row_q == pos_q[5:3]))
          state_d = kbd_pkg::st_idle;
        else if (pass_end && !scan_disable
                 && deb_q == 2'(`KBD_DEB_PASSES - 1))
          state_d = kbd_pkg::st_held;
      kbd_pkg::st_held:
        if (pass_end && !pass_hit_q && !(hit && row_q == pos_q[5:3]))
          state_d = kbd_pkg::st_idle;
      default:
        state_d = kbd_pkg::st_idle;
    endcase
  end

  assign push = (state_q == kbd_pkg::st_debounce)
             && (state_d == kbd_pkg::st_held);
  assign fifo_full  = (count_q == 4'(`KBD_FIFO_DEPTH));
  assign fifo_empty = (count_q == 4'h0);
  assign pop        = data_rd && !fifo_empty;
  assign count_d    = count_q + 4'(push && !fifo_full) - 4'(pop);

  // divider and row scan
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q       <= 9'h000;
      row_q       <= 3'h0;
      row_drive_n <= 8'hFF;
    end
    else
    begin
      div_q <= tick ? 9'h000 : div_q + 9'h001;
      if (tick)
        row_q <= row_q + 3'h1;
      row_drive_n <= scan_disable ? 8'hFF : ~(8'h01 << row_q);
    end
  end

  // closure state, debounce count and key position
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q    <= kbd_pkg::st_idle;
      pos_q      <= 6'h00;
      deb_q      <= 2'h0;
      pass_hit_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == kbd_pkg::st_idle && tick && hit)
        pos_q <= {row_q, hit_col};
      if (state_q == kbd_pkg::st_idle)
        deb_q <= 2'h0;
      else if (pass_end && state_q == kbd_pkg::st_debounce)
        deb_q <= deb_q + 2'h1;
      if (pass_end)
        pass_hit_q <= 1'b0;
      // the detecting tick counts too, as pos_q is only loaded at that edge
      else if (tick && hit && (state_q == kbd_pkg::st_idle
               || (row_q == pos_q[5:3] && col_clean[pos_q[2:0]])))
        pass_hit_q <= 1'b1;
    end
  end

  // fifo storage
  always_ff @(posedge clk)
  begin
    if (push && !fifo_full)
      mem[wr_ptr_q] <= code;
  end

  // fifo pointers, data output and flags
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_q      <= 3'h0;
      rd_ptr_q      <= 3'h0;
      count_q       <= 4'h0;
      fifo_count_q  <= 4'h0;
      data_q        <= 8'h00;
      overrun_q     <= 1'b0;
      underrun_q    <= 1'b0;
      caps_sensed_q <= 1'b0;
    end
    else
    begin
      if (push && !fifo_full)
        wr_ptr_q <= wr_ptr_q + 3'h1;
      if (pop)
      begin
        rd_ptr_q <= rd_ptr_q + 3'h1;
        data_q   <= mem[rd_ptr_q];
      end
      count_q      <= count_d;
      fifo_count_q <= count_d;
      overrun_q    <= (push && fifo_full) || (overrun_q && !err_clear);
      underrun_q   <= (data_rd && fifo_empty)
                   || (underrun_q && !err_clear);
      caps_sensed_q <= mod_clean[2];
    end
  end
endmodule

// ---- logic/kbd_regs.svh ----
// constants for the keyboard matrix encoder
`ifndef KBD_REGS_SVH
`define KBD_REGS_SVH
`define KBD_ROWS          8
`define KBD_CODE_W        8
`define KBD_FIFO_DEPTH    8
`define KBD_CLK_HZ        40000000
`define KBD_SCAN_HZ       100000
`define KBD_SCAN_DIV      (`KBD_CLK_HZ / `KBD_SCAN_HZ)
`define KBD_DEB_PASSES    2
`define KBD_CODE_IDLE     8'hC0
`define KBD_BIT_SHIFT     6
`define KBD_BIT_CTRL      7
`define KBD_FULL_BIT      3
`endif

// ---- logic/kbd_pkg.sv ----
// types for the keyboard matrix encoder
package kbd_pkg;
  typedef enum logic [1:0] {
    st_idle     = 2'b00,
    st_debounce = 2'b01,
    st_held     = 2'b10
  } scan_state_t;
endpackage

// ---- logic/kbd_sync.sv ----
// three-stage input synchroniser with agreement filter
module kbd_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // raw and clean levels
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] clean
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] clean_d;

  // accept a change once stage two and three agree
  assign clean_d = (s2_q == s3_q) ? s2_q : clean;

  // shift chain
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      clean <= '0;
    end
    else
    begin
      s1_q  <= raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      clean <= clean_d;
    end
  end
endmodule

// ---- bench/kbd_encoder_sva.sv ----
// port-level checks for the keyboard matrix encoder
module kbd_encoder_sva (
  // clock and reset
  input wire logic       clk, rst_n,
  // key matrix
  input wire logic [7:0] row_drive_n, col_return_n,
  input wire logic       shift_key_n, ctrl_key_n, fn_modifier_key_n,
  input wire logic       upper_case_latch_key_n,
  // control, data and status
  input wire logic       scan_disable, caps_sensed_q, data_rd, err_clear,
  input wire logic [7:0] data_q,
  input wire logic [3:0] fifo_count_q,
  input wire logic       overrun_q, underrun_q
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  AST_ROWS_BLANK: assert property (
    scan_disable[*4] |-> row_drive_n == 8'hFF)
    else $error("row driven while scan disabled");
  AST_ROW_ONE: assert property (
    $onehot(~row_drive_n) || &row_drive_n)
    else $error("more than one row driven");
  AST_NO_CODE: assert property (
    scan_disable[*8] |=> fifo_count_q <= $past(fifo_count_q))
    else $error("code while disabled");
  AST_POP: assert property (
    data_rd && fifo_count_q != 4'h0 |=> fifo_count_q <= $past(fifo_count_q))
    else $error("read did not pop");
  AST_UNDER_SET: assert property (
    data_rd && fifo_count_q == 4'h0 |=> underrun_q && $stable(data_q))
    else $error("underrun missed");
  AST_MAX: assert property (
    fifo_count_q <= 4'h8)
    else $error("count high");
  AST_STEP: assert property (
    fifo_count_q <= $past(fifo_count_q) + 4'h1)
    else $error("count jumped");
  AST_OVR_HOLD: assert property (
    overrun_q && !err_clear |=> overrun_q)
    else $error("overrun lost");
  AST_CLR: assert property (
    err_clear && !data_rd |=> !underrun_q)
    else $error("underrun not cleared");
  AST_DATA_HOLD: assert property (
    !data_rd |=> $stable(data_q))
    else $error("data changed without read");
endmodule

bind kbd_encoder kbd_encoder_sva chk (.*);

// ---- bench/kbd_matrix_model.sv ----
// one-key matrix: pulls a column low while its row is driven
module kbd_matrix_model (
  // scan side
  input wire logic [7:0] row_drive_n,
  // key position and state
  input wire logic       key_on,
  input wire logic [2:0] key_row, key_col,
  // column returns, pulled up when open
  output logic     [7:0] col_return_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // blank rows give no closure at all
  always_comb
  begin
    col_return_n = 8'hFF;
    if (key_on && !row_drive_n[key_row])
      col_return_n[key_col] = 1'b0;
  end
endmodule

// ---- bench/kbd_encoder_tb.sv ----
// self-checking bench for the keyboard matrix encoder
module kbd_encoder_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 0, rst_n = 0, key_on = 0, data_rd = 0, err_clear = 0;
  logic       shift_n = 1, ctrl_n = 1, fn_n = 1, caps_n = 1, dis = 0;
  logic [7:0] rows_n, cols_n, data_q;
  logic [3:0] cnt;
  logic       caps_q, ovr, und;
  logic [11:0] t;
  int         miscompares = 0, cmp_count = 0;
  // modifier levels beside the code they give, key at row 3 column 5
  logic [11:0] tbl [5] = '{12'hFDD, 12'h79D, 12'hB5D, 12'hD1D, 12'hEDD};
  ////////////////////////////////////////////////////////////////////////
  always #12.5 clk = ~clk;
  kbd_matrix_model mat (.row_drive_n(rows_n), .key_on(key_on),
    .key_row(3'h3), .key_col(3'h5), .col_return_n(cols_n));
  kbd_encoder DUT (.clk(clk), .rst_n(rst_n), .row_drive_n(rows_n),
    .col_return_n(cols_n), .shift_key_n(shift_n), .ctrl_key_n(ctrl_n),
    .fn_modifier_key_n(fn_n), .upper_case_latch_key_n(caps_n),
    .scan_disable(dis), .caps_sensed_q(caps_q), .data_rd(data_rd),
    .data_q(data_q), .err_clear(err_clear), .fifo_count_q(cnt),
    .overrun_q(ovr), .underrun_q(und));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("ERROR %0t got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic rd();
    @(negedge clk) data_rd = 1;
    @(negedge clk) data_rd = 0;
  endtask
  task automatic wait_code();
    for (int n = 0; n < 9000 && cnt !== 4'h1; n++)
      @(negedge clk);
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d of %0d compares", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // watchdog cuts a hang short
  initial
  begin
    #2300000;
    miscompares++;
    report_and_stop();
  end
  // main sequence: reset, underrun, code table via rescan, held key
  initial
  begin
    repeat (10) @(negedge clk);
    chk(data_q, 8'h00);
    chk({4'h0, cnt}, 8'h00);
    chk(rows_n, 8'hFF);
    // scan mode and debounce rate are fixed, so reset alone sets them up
    rst_n = 1;
    rd();
    chk({7'h0, und}, 8'h01);
    chk(data_q, 8'h00);
    @(negedge clk) err_clear = 1;
    @(negedge clk) err_clear = 0;
    chk({7'h0, und}, 8'h00);
    key_on = 1;
    foreach (tbl[i])
    begin
      t = tbl[i];
      {shift_n, ctrl_n, fn_n, caps_n} = t[11:8];
      // blank for two passes so one whole pass is surely missed
      dis = 1;
      repeat (6800) @(negedge clk);
      chk(rows_n, 8'hFF);
      dis = 0;
      wait_code();
      chk({4'h0, cnt}, 8'h01);
      rd();
      chk(data_q, t[7:0]);
      chk({7'h0, caps_q}, {7'h0, ~t[8]});
    end
    repeat (10000) @(negedge clk);
    chk({4'h0, cnt}, 8'h00);
    chk({7'h0, ovr}, 8'h00);
    report_and_stop();
  end
endmodule
